/* File: rtl/pwm_blank_pkg.sv */
// pwm_blank_pkg: register map, field positions, reset values and timing counts
// assumes a 32-bit classic wishbone slave with word-aligned registers
package pwm_blank_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] BLANK_OFS   = 8'h04;
	localparam logic [7:0] RISE_OFS    = 8'h08;
	localparam logic [7:0] FALL_OFS    = 8'h0C;
	localparam logic [7:0] STATUS_OFS  = 8'h10;
	localparam logic [7:0] PERIOD_OFS  = 8'h14;
	// control fields
	localparam int CTRL_FILT_EN  = 0;
	localparam int CTRL_SHADOW   = 1;
	localparam int CTRL_BLANK_EN = 2;
	localparam int CTRL_EVT_INV  = 3;
	localparam int CTRL_PWM_EN   = 4;
	localparam int CTRL_W        = 5;
	// blank register: start offset in [15:0], width in [31:16]
	localparam int BLANK_START_LSB = 0;
	localparam int BLANK_WID_LSB   = 16;
	localparam int CNT_W           = 16;
	localparam int DELAY_W         = 10;
	// status fields
	localparam int STS_FILT   = 0;
	localparam int STS_BLANK  = 1;
	localparam int STS_TRIP   = 2;
	localparam int STS_PWMA   = 3;
	localparam int STS_PWMB   = 4;
	// reset values
	localparam logic [CTRL_W-1:0]  CTRL_RST   = 5'h00;
	localparam logic [CNT_W-1:0]   PERIOD_RST = 16'h00FF;
	localparam logic [DELAY_W-1:0] DELAY_RST  = 10'h001;
	// the window needs this many cycles from its start before it masks
	localparam int BLANK_LATENCY = 3;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : pwm_blank_pkg

/* File: rtl/delay_if.sv */
// delay_if: carries one edge-delay setting from the register file to a delay unit
// assumes both ends sit on core_clk
`timescale 1ns/1ps
interface delay_if #(parameter int W = 10);
	logic         wrStb;
	logic [W-1:0] wrVal;
	logic         shadowMode;
	logic         loadEvt;
	logic [W-1:0] active;
	modport ctl (output wrStb, output wrVal, output shadowMode, output loadEvt, input active);
	modport dly (input wrStb, input wrVal, input shadowMode, input loadEvt, output active);
endinterface : delay_if

/* File: rtl/edge_delay.sv */
// edge_delay: shadowed delay register plus a counter that delays one edge
// assumes the load event is a one-cycle pulse at the period wrap
`timescale 1ns/1ps
module edge_delay
	import pwm_blank_pkg::*;
#(
	parameter int W = DELAY_W
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic clkEn,
	delay_if.dly      cfg,
	input  wire logic inSig,
	output logic      outSig
);
	logic [W-1:0] shadow_r,  shadow_nxt;
	logic [W-1:0] active_r,  active_nxt;
	logic [W-1:0] cnt_r,     cnt_nxt;
	logic         out_r,     out_nxt;

	always_comb begin
		shadow_nxt = shadow_r;
		active_nxt = active_r;
		if (cfg.wrStb) begin
			shadow_nxt = cfg.wrVal;
			if (!cfg.shadowMode) begin
				active_nxt = cfg.wrVal; // R12
			end
		end
		if (cfg.shadowMode && cfg.loadEvt) begin
			// the shadow path cannot deliver a zero delay, so it loads one instead
			active_nxt = (shadow_r == '0) ? W'(1) : shadow_r; // R5 R12
		end
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		if (!inSig) begin
			out_nxt = 1'b0;
			cnt_nxt = '0;
		end else if (!out_r) begin
			// counts whole cycles, so a delay of one differs from zero
			if (cnt_r >= active_r) begin
				out_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + W'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shadow_r <= DELAY_RST;
			active_r <= DELAY_RST;
			cnt_r    <= '0;
			out_r    <= 1'b0;
		end else if (clkEn) begin
			shadow_r <= shadow_nxt;
			active_r <= active_nxt;
			cnt_r    <= cnt_nxt;
			out_r    <= out_nxt;
		end
	end

	assign cfg.active = active_r;
	assign outSig     = out_r;
endmodule : edge_delay

/* File: rtl/sync2.sv */
// sync2: two-flop level synchroniser for pin inputs
// assumes the input is asynchronous to core_clk
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 2
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         clkEn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_r, s2_r;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= '0;
			s2_r <= '0;
		end else if (clkEn) begin
			s1_r <= din;
			s2_r <= s1_r;
		end
	end
	assign dout = s2_r;
endmodule : sync2

/* File: rtl/pwm_trip_blanking_deadband.sv */
// pwm_trip_blanking_deadband: pwm counter, trip blanking window and dead-band
// assumes a classic wishbone master on core_clk and asynchronous trip pins
//
// Overview of operation
// R1: blanking window masks trip events
// R2: trip outlasting window end may glitch
// R3: late trip end: pulse or stay active
// R4: software keeps trip ends off window edge
// R5: shadow zero delay unsupported, forced to one
// R6: software uses immediate mode for zero
// R7: first three window cycles do not mask
// R8: filtered event follows inputs while unmasked
// R9: enabled filtered event drives trip consumers
// R10: window persists across period wrap
// R11: software starts window three cycles early
// R12: shadow delay loads at wrap, immediate now
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module pwm_trip_blanking_deadband
	import pwm_blank_pkg::*;
#(
	parameter int NEVT = 2
) (
	input  wire logic            core_clk,
	input  wire logic            resetn,
	input  wire logic            clkEn,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic [NEVT-1:0] compare_event_inputs,
	output logic                 filtered_compare_event,
	output logic                 trip_zone,
	output logic                 tripIrq,
	output logic                 socTrig,
	output logic                 pwmA,
	output logic                 pwmB
);
	logic [CTRL_W-1:0]  ctrl_r,   ctrl_nxt;
	logic [CNT_W-1:0]   bStart_r, bStart_nxt;
	logic [CNT_W-1:0]   bWid_r,   bWid_nxt;
	logic [CNT_W-1:0]   period_r, period_nxt;
	logic [CNT_W-1:0]   cnt_r,    cnt_nxt;
	logic [CNT_W-1:0]   bCnt_r,   bCnt_nxt;
	logic [1:0]         bAge_r,   bAge_nxt;
	logic               bOn_r,    bOn_nxt;
	logic               filt_r,   filt_nxt;
	logic               trip_r,   trip_nxt;
	logic               irq_r,    irq_nxt;
	logic               soc_r,    soc_nxt;
	logic               pA_r,     pA_nxt;
	logic               pB_r,     pB_nxt;
	logic               ack_r,    ack_nxt;
	logic [31:0]        rd_r,     rd_nxt;
	logic [NEVT-1:0]    evtSync;
	logic               evtAny, wrap, masking, raw, rOut, fOut, wrAcc;

	delay_if #(.W(DELAY_W)) riseIf ();
	delay_if #(.W(DELAY_W)) fallIf ();

	sync2 #(.W(NEVT)) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.din      (compare_event_inputs),
		.dout     (evtSync)
	);

	edge_delay #(.W(DELAY_W)) u_rising (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.cfg      (riseIf.dly),
		.inSig    (raw),
		.outSig   (rOut)
	);

	edge_delay #(.W(DELAY_W)) u_falling (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.cfg      (fallIf.dly),
		.inSig    (~raw),
		.outSig   (fOut)
	);

	assign wrAcc = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
	assign wrap  = (cnt_r == period_r);
	assign raw   = (cnt_r < (period_r >> 1));

	assign riseIf.wrStb      = wrAcc && (wb_adr_i == RISE_OFS);
	assign riseIf.wrVal      = wb_dat_i[DELAY_W-1:0];
	assign riseIf.shadowMode = ctrl_r[CTRL_SHADOW];
	assign riseIf.loadEvt    = wrap;
	assign fallIf.wrStb      = wrAcc && (wb_adr_i == FALL_OFS);
	assign fallIf.wrVal      = wb_dat_i[DELAY_W-1:0];
	assign fallIf.shadowMode = ctrl_r[CTRL_SHADOW];
	assign fallIf.loadEvt    = wrap;

	// masking only after the window has aged past its start latency
	assign masking = bOn_r && (bAge_r == 2'(BLANK_LATENCY)); // R1 R7
	assign evtAny  = (|evtSync) ^ ctrl_r[CTRL_EVT_INV];

	// pwm counter and blanking window
	always_comb begin
		cnt_nxt  = wrap ? '0 : cnt_r + CNT_W'(1);
		bOn_nxt  = bOn_r;
		bCnt_nxt = bCnt_r;
		bAge_nxt = bAge_r;
		// window start compares against the counter; the wrap does not end it
		if (ctrl_r[CTRL_BLANK_EN] && cnt_r == bStart_r && !bOn_r) begin
			bOn_nxt  = (bWid_r != '0);
			bCnt_nxt = bWid_r;
			bAge_nxt = '0;
		end else if (bOn_r) begin // R10
			if (bAge_r != 2'(BLANK_LATENCY)) begin
				bAge_nxt = bAge_r + 2'd1;
			end
			bCnt_nxt = bCnt_r - CNT_W'(1);
			if (bCnt_r == CNT_W'(1)) begin
				bOn_nxt = 1'b0;
			end
		end
	end

	// filtered event and its consumers; a trip ending right at window close
	// reaches the outputs unmasked for a cycle, a brief trip pulse
	always_comb begin
		filt_nxt = masking ? 1'b0 : evtAny; // R8 R2 R3
		trip_nxt = ctrl_r[CTRL_FILT_EN] && filt_r; // R9
		irq_nxt  = trip_nxt && !trip_r; // R9
		soc_nxt  = irq_nxt; // R9
		pA_nxt   = ctrl_r[CTRL_PWM_EN] && rOut && !trip_nxt; // R9
		pB_nxt   = ctrl_r[CTRL_PWM_EN] && fOut && !trip_nxt; // R9
	end

	// register file: a write needs byte lane zero; unmapped writes fall away
	always_comb begin
		ctrl_nxt   = ctrl_r;
		bStart_nxt = bStart_r;
		bWid_nxt   = bWid_r;
		period_nxt = period_r;
		if (wrAcc) begin
			case (wb_adr_i)
				CTRL_OFS: begin
					ctrl_nxt = wb_dat_i[CTRL_W-1:0];
				end
				BLANK_OFS: begin
					bStart_nxt = wb_dat_i[BLANK_START_LSB +: CNT_W];
					bWid_nxt   = wb_dat_i[BLANK_WID_LSB +: CNT_W];
				end
				PERIOD_OFS: begin
					period_nxt = wb_dat_i[CNT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// wishbone answer: one-cycle ack, dropped the cycle after
	always_comb begin
		ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
		rd_nxt  = rd_r;
		if (ack_nxt && !wb_we_i) begin
			case (wb_adr_i)
				CTRL_OFS:   rd_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
				BLANK_OFS:  rd_nxt = {bWid_r, bStart_r};
				RISE_OFS:   rd_nxt = {{(32-DELAY_W){1'b0}}, riseIf.active};
				FALL_OFS:   rd_nxt = {{(32-DELAY_W){1'b0}}, fallIf.active};
				PERIOD_OFS: rd_nxt = {{(32-CNT_W){1'b0}}, period_r};
				STATUS_OFS: rd_nxt = {27'h000_0000, pB_r, pA_r, trip_r, bOn_r, filt_r};
				default:    rd_nxt = UNMAPPED_DATA;
			endcase
		end
	end

	// register file
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r   <= CTRL_RST;
			bStart_r <= '0;
			bWid_r   <= '0;
			period_r <= PERIOD_RST;
		end else if (clkEn) begin
			ctrl_r   <= ctrl_nxt;
			bStart_r <= bStart_nxt;
			bWid_r   <= bWid_nxt;
			period_r <= period_nxt;
		end
	end

	// wishbone answer; a frozen clock enable holds ack as well
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ack_r <= 1'b0;
			rd_r  <= '0;
		end else if (clkEn) begin
			ack_r <= ack_nxt;
			rd_r  <= rd_nxt;
		end
	end

	// pwm counter and blanking window
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= '0;
			bCnt_r <= '0;
			bAge_r <= '0;
			bOn_r  <= 1'b0;
		end else if (clkEn) begin
			cnt_r  <= cnt_nxt;
			bCnt_r <= bCnt_nxt;
			bAge_r <= bAge_nxt;
			bOn_r  <= bOn_nxt;
		end
	end

	// filtered event and its consumers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			filt_r <= 1'b0;
			trip_r <= 1'b0;
			irq_r  <= 1'b0;
			soc_r  <= 1'b0;
			pA_r   <= 1'b0;
			pB_r   <= 1'b0;
		end else if (clkEn) begin
			filt_r <= filt_nxt;
			trip_r <= trip_nxt;
			irq_r  <= irq_nxt;
			soc_r  <= soc_nxt;
			pA_r   <= pA_nxt;
			pB_r   <= pB_nxt;
		end
	end

	assign wb_ack_o               = ack_r;
	assign wb_dat_o               = rd_r;
	assign filtered_compare_event = filt_r;
	assign trip_zone              = trip_r;
	assign tripIrq                = irq_r;
	assign socTrig                = soc_r;
	assign pwmA                   = pA_r;
	assign pwmB                   = pB_r;
endmodule : pwm_trip_blanking_deadband

/* File: bench/trip_comparator.sv */
// trip_comparator: model of the trip comparators feeding the event pins
// assumes requests come from the bench on core_clk edges
`timescale 1ns/1ps
module trip_comparator (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [1:0] tripReq,
	output logic      [1:0] compare_event_inputs
);
	// one register of comparator latency, so pins never move with the request
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			compare_event_inputs <= 2'h0;
		end else begin
			compare_event_inputs <= tripReq;
		end
	end
endmodule : trip_comparator

/* File: bench/pwm_blank_monitor.sv */
// pwm_blank_monitor: port-level checks for the bus, event path and trip outputs
// assumes the bind below and that the event never rises while inverted
`timescale 1ns/1ps
module pwm_blank_monitor #(
	parameter int NEVT = 2
) (
	input wire logic            core_clk,
	input wire logic            resetn,
	input wire logic            clkEn,
	input wire logic            wb_cyc_i,
	input wire logic            wb_stb_i,
	input wire logic            wb_we_i,
	input wire logic [7:0]      wb_adr_i,
	input wire logic [3:0]      wb_sel_i,
	input wire logic [31:0]     wb_dat_i,
	input wire logic [31:0]     wb_dat_o,
	input wire logic            wb_ack_o,
	input wire logic [NEVT-1:0] compare_event_inputs,
	input wire logic            filtered_compare_event,
	input wire logic            trip_zone,
	input wire logic            tripIrq,
	input wire logic            socTrig,
	input wire logic            pwmA,
	input wire logic            pwmB
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
	endsequence
	ack_latency_a: assert property (take_s |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o && clkEn |=> !wb_ack_o) else $error("ack long");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack unasked");
	rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("rdata moved");
	// two sync flops plus the filter register
	filt_cause_a: assert property ($rose(filtered_compare_event) |->
		$past(|compare_event_inputs, 3)) else $error("event rose early");
	trip_cause_a: assert property ($rose(trip_zone) |->
		$past(filtered_compare_event)) else $error("trip uncaused");
	irq_pulse_a: assert property (tripIrq |=> !tripIrq) else $error("irq long");
	soc_same_a: assert property (socTrig == tripIrq) else $error("soc differs");
	pwm_trip_a: assert property (trip_zone |-> !pwmA && !pwmB) else $error("pwm in trip");
endmodule : pwm_blank_monitor
bind pwm_trip_blanking_deadband pwm_blank_monitor #(.NEVT(NEVT)) u_pwm_blank_monitor (.*);

/* File: bench/pwm_trip_blanking_deadband_tb.sv */
// pwm_trip_blanking_deadband_tb: register, dead-band and blanking tests
// assumes the comparator model drives the trip pins
`timescale 1ns/1ps
module pwm_trip_blanking_deadband_tb;
	import pwm_blank_pkg::*;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        en = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat, q;
	logic [1:0]  tripReq = 2'h0;
	logic [1:0]  evt;
	logic        ack, fce, tz, irq, soc, pa, pb;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          irqSeen = 0;
	int          n, len;
	logic [7:0]  ra [6] = '{CTRL_OFS, PERIOD_OFS, RISE_OFS, FALL_OFS, BLANK_OFS, 8'h18};
	logic [31:0] rv [6] = '{32'(CTRL_RST), 32'(PERIOD_RST), 32'(DELAY_RST),
		32'(DELAY_RST), 32'h0000_0000, UNMAPPED_DATA};
	logic [15:0] st [2] = '{16'h0010, 16'h00F0};
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (irq === 1'b1) begin
			irqSeen++;
		end
	end
	trip_comparator u_trip_comparator (.core_clk(core_clk), .resetn(resetn),
		.tripReq(tripReq), .compare_event_inputs(evt));
	pwm_trip_blanking_deadband u_pwm_trip_blanking_deadband (.core_clk(core_clk),
		.resetn(resetn), .clkEn(en), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.compare_event_inputs(evt), .filtered_compare_event(fce), .trip_zone(tz),
		.tripIrq(irq), .socTrig(soc), .pwmA(pa), .pwmB(pb));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	task automatic bad(input string m);
		miscompares++;
		$display("BAD %0t %s", $time, m);
	endtask : bad
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad($sformatf("saw %h want %h", s, e));
		end
	endtask : chk
	task automatic guard(input int i);
		if (i >= 600) begin
			bad("timeout");
			report_and_stop();
		end
	endtask : guard
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		for (i = 0; i < 600 && ack !== 1'b1; i++) begin
			@(posedge core_clk);
		end
		guard(i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	// counts the cycles of one low run of the filtered event
	task automatic low_run(output int l);
		int i;
		l = 0;
		for (i = 0; i < 600 && fce !== 1'b0; i++) begin
			@(posedge core_clk);
		end
		guard(i);
		for (i = 0; i < 600 && fce === 1'b0; i++) begin
			@(posedge core_clk);
			l++;
		end
		guard(i);
	endtask : low_run
	initial begin
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		for (n = 0; n < 6; n++) begin
			wb(1'b0, ra[n], 32'h0000_0000, 4'hF);
			chk(q, rv[n]);
		end
		wb(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
		wb(1'b1, CTRL_OFS, 32'h0000_001F, 4'hE);
		wb(1'b0, CTRL_OFS, 32'h0000_0000, 4'hF);
		chk(q, 32'h0000_0000);
		$display("register test done");
		wb(1'b1, CTRL_OFS, 32'h0000_0010, 4'hF);
		wb(1'b1, RISE_OFS, 32'h0000_0000, 4'hF);
		wb(1'b0, RISE_OFS, 32'h0000_0000, 4'hF);
		chk(q, 32'h0000_0000);
		// zero in shadow mode is written on purpose here, to see it refused
		wb(1'b1, CTRL_OFS, 32'h0000_0012, 4'hF);
		wb(1'b1, RISE_OFS, 32'h0000_0000, 4'hF);
		wb(1'b1, FALL_OFS, 32'h0000_0007, 4'hF);
		repeat (300) @(posedge core_clk);
		wb(1'b0, RISE_OFS, 32'h0000_0000, 4'hF);
		chk(q, 32'h0000_0001);
		wb(1'b0, FALL_OFS, 32'h0000_0000, 4'hF);
		chk(q, 32'h0000_0007);
		$display("delay test done");
		wb(1'b1, CTRL_OFS, 32'h0000_0010, 4'hF);
		tripReq <= 2'h1;
		repeat (10) @(posedge core_clk);
		chk(32'(tz), 32'h0000_0000);
		wb(1'b1, CTRL_OFS, 32'h0000_0011, 4'hF);
		repeat (10) @(posedge core_clk);
		chk(32'(tz), 32'h0000_0001);
		chk(32'(pa), 32'h0000_0000);
		chk(32'(pb), 32'h0000_0000);
		chk(32'(irqSeen), 32'h0000_0001);
		// freeze: the pins fall, but the trip must hold until the enable returns
		en <= 1'b0;
		tripReq <= 2'h0;
		repeat (10) @(posedge core_clk);
		chk(32'(tz), 32'h0000_0001);
		en <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk(32'(tz), 32'h0000_0000);
		tripReq <= 2'h2;
		// second start crosses the wrap; a window cut at wrap would run short
		for (n = 0; n < 2; n++) begin
			wb(1'b1, BLANK_OFS, {16'h0040, st[n]}, 4'hF);
			wb(1'b1, CTRL_OFS, 32'h0000_0015, 4'hF);
			low_run(len);
			low_run(len);
			chk(32'(len), 32'(16'h0040 - BLANK_LATENCY));
		end
		// inverted event with the pins high must read as no event
		wb(1'b1, CTRL_OFS, 32'h0000_0009, 4'hF);
		repeat (10) @(posedge core_clk);
		chk(32'(fce), 32'h0000_0000);
		chk(32'(tz), 32'h0000_0000);
		wb(1'b1, CTRL_OFS, 32'h0000_0000, 4'hF);
		tripReq <= 2'h0;
		$display("blanking test done");
		report_and_stop();
	end
endmodule : pwm_trip_blanking_deadband_tb
